// >>> rtl/exec_unit.sv
// Purpose: Executes move, OR and increment/decrement-skip operations on an accumulator
//          and a 128-entry file register array.
// Assumes: Operation inputs are held stable and sampled on each instruction-cycle pulse.
// Notes: A taken skip swallows the next presented instruction as a no-operation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Decrement file; result to accumulator or file.
// - Zero decrement result skips next instruction.
// - Increment file; result to accumulator or file.
// - Zero increment result skips next instruction.
// - OR literal into accumulator; update zero.
// - Load literal into accumulator, flags untouched.
// - OR accumulator with file to destination; zero.
// - Store accumulator to file, flags untouched.
// - Move file to destination; update zero.
// - Move to file keeps contents, updates zero.
module exec_unit #(
  parameter int DATA_W = exec_pkg::DATA_W,
  parameter int ADDR_W = exec_pkg::ADDR_W,
  parameter int DEPTH = exec_pkg::FILE_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Instruction presented for the current instruction cycle.
  input wire exec_pkg::exec_op_t op_in,
  input wire logic [ADDR_W-1:0] file_addr_in,
  input wire logic [DATA_W-1:0] literal_in,
  input wire logic dest_in,
  // Debug read port into the file registers.
  input wire logic [ADDR_W-1:0] peek_addr_in,
  output logic [DATA_W-1:0] peek_data_out,
  // Core state.
  output logic [DATA_W-1:0] acc_out,
  output logic zero_flag_out,
  output logic tcy_tick_out,
  output logic skipping_out,
  output logic op_done_out
);
  import exec_pkg::*;

  // ==========================================================
  // Instruction cycle enable.
  logic tick;

  tcy_divider #(
    .DIV(TCY_CYCLES)
  ) u_div (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .tick_out(tick)
  );

  // ==========================================================
  // State.
  logic [DATA_W-1:0] file_mem [DEPTH];
  logic [DATA_W-1:0] acc_ff;
  logic [DATA_W-1:0] nxt_acc;
  logic zero_ff;
  logic nxt_zero;
  exec_state_t state_ff;
  exec_state_t nxt_state;
  logic done_ff;
  logic nxt_done;
  logic [DATA_W-1:0] peek_ff;
  logic file_we;
  logic [DATA_W-1:0] file_wdata;
  logic [DATA_W-1:0] file_rdata;
  logic [DATA_W-1:0] result;

  // Operations that honour the destination select bit.
  function automatic logic uses_dest(input exec_op_t op);
    return (op == OP_DEC_SKIP) || (op == OP_INC_SKIP) ||
           (op == OP_OR_FILE) || (op == OP_MOVE_FILE);
  endfunction

  assign file_rdata = file_mem[file_addr_in];

  // ==========================================================
  // Datapath and sequencing.
  always_comb begin
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_state = state_ff;
    nxt_done = 1'b0;
    file_we = 1'b0;
    file_wdata = file_rdata;
    result = '0;
    if (tick) begin
      if (state_ff == ST_SKIP) begin
        // The discarded instruction executes as a no-operation.
        nxt_state = ST_RUN;
        nxt_done = 1'b1;
      end else begin
        nxt_done = (op_in != OP_NONE);
        case (op_in)
          OP_DEC_SKIP: begin
            result = file_rdata - DATA_W'(1);
            if (result == '0) begin
              nxt_state = ST_SKIP;
            end
          end
          OP_INC_SKIP: begin
            result = file_rdata + DATA_W'(1);
            if (result == '0) begin
              nxt_state = ST_SKIP;
            end
          end
          OP_OR_LIT: begin
            result = acc_ff | literal_in;
            nxt_acc = result;
            nxt_zero = (result == '0);
          end
          OP_LOAD_LIT: begin
            result = literal_in;
            nxt_acc = result;
          end
          OP_OR_FILE: begin
            result = acc_ff | file_rdata;
            nxt_zero = (result == '0);
          end
          OP_STORE_ACC: begin
            result = acc_ff;
            file_we = 1'b1;
            file_wdata = result;
          end
          OP_MOVE_FILE: begin
            // Rewriting the same value lets software test a register in place.
            result = file_rdata;
            nxt_zero = (result == '0);
          end
          default: begin
            result = '0;
          end
        endcase
        if (uses_dest(op_in)) begin
          if (dest_in == DEST_FILE) begin
            file_we = 1'b1;
            file_wdata = result;
          end else begin
            nxt_acc = result;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_ff <= ACC_RESET;
      zero_ff <= ZERO_RESET;
      state_ff <= ST_RUN;
      done_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      state_ff <= nxt_state;
      done_ff <= nxt_done;
    end
  end

  // ==========================================================
  // File registers.
  // Reset clears the array so every read is defined; this costs a wide reset tree.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_mem[i] <= FILE_RESET;
      end
      peek_ff <= FILE_RESET;
    end else begin
      if (file_we) begin
        file_mem[file_addr_in] <= file_wdata;
      end
      peek_ff <= file_mem[peek_addr_in];
    end
  end

  assign acc_out = acc_ff;
  assign zero_flag_out = zero_ff;
  assign tcy_tick_out = tick;
  assign skipping_out = (state_ff == ST_SKIP);
  assign op_done_out = done_ff;
  assign peek_data_out = peek_ff;
endmodule
`default_nettype wire

// >>> inc/exec_pkg.sv
// Purpose: Shared constants and types for the move, OR and increment/decrement-skip datapath.
// Assumes: One instruction is presented per instruction-cycle enable pulse.
// Notes: Operation codes are local encodings of this block, not opcode bits.
`default_nettype none
package exec_pkg;
  // ==========================================================
  // Widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  // ==========================================================
  // Reset values.
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [7:0] FILE_RESET = 8'h00;
  // ==========================================================
  // Destination select values.
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // ==========================================================
  // Instruction cycle divider: 100 MHz core clock, 200 ns instruction cycle.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCY_NS = 200;
  localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Operations handled by this block.
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DEC_SKIP = 3'b001,
    OP_INC_SKIP = 3'b010,
    OP_OR_LIT = 3'b011,
    OP_LOAD_LIT = 3'b100,
    OP_OR_FILE = 3'b101,
    OP_STORE_ACC = 3'b110,
    OP_MOVE_FILE = 3'b111
  } exec_op_t;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_SKIP = 1'b1
  } exec_state_t;
endpackage
`default_nettype wire

// >>> rtl/tcy_divider.sv
// Purpose: Produces the one-cycle instruction-cycle enable pulse.
// Assumes: Single core clock.
// Notes: The first pulse comes TCY_CYCLES clocks after reset release.
`timescale 1ns/1ps
`default_nettype none
module tcy_divider #(
  parameter int DIV = 20
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Enable pulse.
  output logic tick_out
);
  localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff + CNT_W'(1);
    nxt_tick = 1'b0;
    if (cnt_ff == CNT_LAST) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;
endmodule
`default_nettype wire

// >>> dv/exec_unit_properties.sv
// Purpose: Port-level assertions for the execution unit.
// Assumes: Inputs hold steady across each instruction tick.
// Notes: File contents are judged by the bench through the peek port.
`timescale 1ns/1ps
`default_nettype none
module exec_unit_chk #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int DEPTH = 128
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Instruction.
  input wire exec_pkg::exec_op_t op_in,
  input wire logic [ADDR_W-1:0] file_addr_in,
  input wire logic [DATA_W-1:0] literal_in,
  input wire logic dest_in,
  // Observed state.
  input wire logic [ADDR_W-1:0] peek_addr_in,
  input wire logic [DATA_W-1:0] peek_data_out,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic zero_flag_out,
  input wire logic tcy_tick_out,
  input wire logic skipping_out,
  input wire logic op_done_out
);
  import exec_pkg::*;
  // ==========================================================
  // Properties.
  logic run;
  assign run = tcy_tick_out && !skipping_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  tick_period_a: assert property (tcy_tick_out |-> ##20 tcy_tick_out)
    else $error("tick spacing wrong");
  done_cause_a: assert property (op_done_out |-> $past(tcy_tick_out))
    else $error("done without tick");
  load_lit_a: assert property (run && op_in == OP_LOAD_LIT |=>
    acc_out == $past(literal_in) && $stable(zero_flag_out)) else $error("load wrong");
  or_lit_a: assert property (run && op_in == OP_OR_LIT |=>
    acc_out == ($past(acc_out) | $past(literal_in)) && zero_flag_out == (acc_out == 8'h00))
    else $error("or literal wrong");
  flags_kept_a: assert property (run && op_in inside {OP_DEC_SKIP, OP_INC_SKIP,
    OP_STORE_ACC} |=> $stable(zero_flag_out)) else $error("flag moved");
  skip_slot_a: assert property (tcy_tick_out && skipping_out |=>
    $stable(acc_out) && $stable(zero_flag_out) && !skipping_out) else $error("slot ran");
  skip_zero_a: assert property (run && op_in inside {OP_DEC_SKIP, OP_INC_SKIP} &&
    dest_in == DEST_ACC |=> skipping_out == (acc_out == 8'h00)) else $error("skip wrong");
  zero_acc_a: assert property (run && op_in inside {OP_OR_FILE, OP_MOVE_FILE} &&
    dest_in == DEST_ACC |=> zero_flag_out == (acc_out == 8'h00)) else $error("zero wrong");
  move_keep_a: assert property (run && op_in == OP_MOVE_FILE &&
    dest_in == DEST_FILE |=> $stable(acc_out)) else $error("move changed acc");
  cover property (tcy_tick_out && skipping_out);
  cover property (run && op_in == OP_OR_LIT);
  cover property (run && op_in == OP_MOVE_FILE && dest_in == DEST_FILE);
endmodule
bind exec_unit exec_unit_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .DEPTH(DEPTH)) chk_u (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .op_in(op_in), .dest_in(dest_in),
  .file_addr_in(file_addr_in), .literal_in(literal_in), .peek_addr_in(peek_addr_in),
  .peek_data_out(peek_data_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
  .tcy_tick_out(tcy_tick_out), .skipping_out(skipping_out), .op_done_out(op_done_out));
`default_nettype wire

// >>> dv/mcu_move_or_incdec_skip_ops_bench.sv
// Purpose: Self-checking bench for the execution unit.
// Assumes: Instruction cycle of 20 core clocks.
// Notes: Rows chain, each starting from the state the row before left.
`timescale 1ns/1ps
`default_nettype none
module mcu_move_or_incdec_skip_ops_bench;
  import exec_pkg::*;
  typedef struct packed {
    exec_op_t op; logic [6:0] a; logic [7:0] k; logic d; logic [7:0] w; logic z; logic s;
  } row_t;
  // ==========================================================
  // Stimulus and wiring.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  exec_op_t op = OP_NONE;
  logic [6:0] adr = 7'h00;
  logic [6:0] padr = 7'h00;
  logic [7:0] lit = 8'h00;
  logic dst = 1'b0;
  logic [7:0] peek, acc;
  logic z, tick, sk, done;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // The slot rows after a taken skip would change state if they were not discarded.
  row_t rows[20] = '{'{OP_LOAD_LIT, 7'h0, 8'h5a, 1'h0, 8'h5a, 1'h0, 1'h0},
    '{OP_OR_LIT, 7'h0, 8'ha5, 1'h0, 8'hff, 1'h0, 1'h0},
    '{OP_STORE_ACC, 7'h3, 8'h0, 1'h1, 8'hff, 1'h0, 1'h0},
    '{OP_LOAD_LIT, 7'h0, 8'h0, 1'h0, 8'h00, 1'h0, 1'h0},
    '{OP_OR_LIT, 7'h0, 8'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{OP_MOVE_FILE, 7'h3, 8'h0, 1'h0, 8'hff, 1'h0, 1'h0},
    '{OP_INC_SKIP, 7'h3, 8'h0, 1'h1, 8'hff, 1'h0, 1'h1},
    '{OP_LOAD_LIT, 7'h0, 8'h11, 1'h0, 8'hff, 1'h0, 1'h0},
    '{OP_MOVE_FILE, 7'h3, 8'h0, 1'h1, 8'hff, 1'h1, 1'h0},
    '{OP_OR_FILE, 7'h3, 8'h0, 1'h0, 8'hff, 1'h0, 1'h0},
    '{OP_LOAD_LIT, 7'h0, 8'h0, 1'h0, 8'h00, 1'h0, 1'h0},
    '{OP_OR_FILE, 7'h3, 8'h0, 1'h1, 8'h00, 1'h1, 1'h0},
    '{OP_DEC_SKIP, 7'h3, 8'h0, 1'h0, 8'hff, 1'h1, 1'h0},
    '{OP_DEC_SKIP, 7'h7, 8'h0, 1'h1, 8'hff, 1'h1, 1'h0},
    '{OP_INC_SKIP, 7'h7, 8'h0, 1'h0, 8'h00, 1'h1, 1'h1},
    '{OP_STORE_ACC, 7'h7, 8'h0, 1'h0, 8'h00, 1'h1, 1'h0},
    '{OP_LOAD_LIT, 7'h0, 8'h01, 1'h0, 8'h01, 1'h1, 1'h0},
    '{OP_STORE_ACC, 7'h9, 8'h0, 1'h0, 8'h01, 1'h1, 1'h0},
    '{OP_DEC_SKIP, 7'h9, 8'h0, 1'h1, 8'h01, 1'h1, 1'h1},
    '{OP_OR_LIT, 7'h0, 8'hff, 1'h0, 8'h01, 1'h1, 1'h0}};
  always #5 clk = ~clk;
  exec_unit dut_u (.sys_clk_in(clk), .resetn_in(resetn), .op_in(op), .file_addr_in(adr),
    .literal_in(lit), .dest_in(dst), .peek_addr_in(padr), .peek_data_out(peek),
    .acc_out(acc), .zero_flag_out(z), .tcy_tick_out(tick), .skipping_out(sk),
    .op_done_out(done));
  // ==========================================================
  // Tasks.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Waits for the edge that takes the presented instruction, then lets it settle.
  task automatic wait_tick();
    do @(posedge clk); while (tick !== 1'b1);
    #1;
  endtask
  task automatic peek_chk(input logic [6:0] a, input logic [7:0] exp);
    padr = a;
    repeat (2) @(posedge clk);
    #1;
    chk("file", exp, peek);
  endtask
  // A hang is cut short well past the expected run of some 500 clocks.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Sequence.
  initial begin
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    foreach (rows[i]) begin
      op = rows[i].op;
      adr = rows[i].a;
      lit = rows[i].k;
      dst = rows[i].d;
      wait_tick();
      chk("acc", rows[i].w, acc);
      chk("zero", 8'(rows[i].z), 8'(z));
      chk("skip", 8'(rows[i].s), 8'(sk));
      chk("done", 8'h01, 8'(done));
    end
    peek_chk(7'h03, 8'h00);
    peek_chk(7'h07, 8'hff);
    peek_chk(7'h09, 8'h00);
    resetn = 1'b0;
    #1;
    chk("acc reset", 8'h00, acc);
    chk("zero reset", 8'h00, 8'(z));
    chk("skip reset", 8'h00, 8'(sk));
    chk("done reset", 8'h00, 8'(done));
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    peek_chk(7'h07, 8'h00);
    op = OP_OR_LIT;
    lit = 8'h00;
    wait_tick();
    chk("zero", 8'h01, 8'(z));
    // An empty slot must leave state alone and raise no completion pulse.
    op = OP_NONE;
    wait_tick();
    chk("idle done", 8'h00, 8'(done));
    chk("idle acc", 8'h00, acc);
    chk("idle zero", 8'h01, 8'(z));
    // A nonzero OR result sent to a cleared file proves the file write path.
    op = OP_LOAD_LIT;
    lit = 8'h3c;
    wait_tick();
    chk("load acc", 8'h3c, acc);
    op = OP_OR_FILE;
    adr = 7'h05;
    dst = DEST_FILE;
    wait_tick();
    chk("or file acc", 8'h3c, acc);
    chk("or file zero", 8'h00, 8'(z));
    peek_chk(7'h05, 8'h3c);
    tally_and_finish();
  end
endmodule
`default_nettype wire
